// ---- rtl/rtccv_core.sv ----
// Operation
// - year byte holds tens 7-4, ones 3-0, upper byte reads zero.
// - month tens at bit 12, ones 11-8; read-only in time window.
// - day tens 5-4, ones 3-0; bits 7-6 and 15-13 read zero.
// - weekday in bits 10-8, range 0 to 6, bits 15-11 zero.
// - hour tens 5-4 range 0 to 2, ones 3-0.
// - minute tens 14-12, ones 11-8, bit 15 reads zero.
// - second tens 6-4, ones 3-0, bit 7 reads zero.
// - time year, month/day, weekday/hour writes only while unlock bit set.
// - alarm month/day and weekday/hour share layout, writable only when unlocked.
// - unimplemented upper bits read zero and hold no state.
// - each minute, signed trim times four pulses adjusts the timer count.
// - negative trim subtracts pulses, positive trim adds pulses.
// - two-bit pointer selects window pair; each access decrements until zero.
// - half-second flag clears on a write to minute/second register while unlock bit set.
`default_nettype none
module rtccv_core (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_xtal,
  input wire logic [rtccv_pkg::ADDR_W-1:0] i_addr,
  input wire logic [rtccv_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [rtccv_pkg::DATA_W-1:0] o_rdata,
  output logic o_second_pulse
);
  rtccv_pkg::rtccv_time_type time_q;
  rtccv_pkg::rtccv_time_type alarm_q;
  rtccv_pkg::rtccv_time_type time_adv;
  logic en_q;
  logic unlock_q;
  logic [1:0] ptr_q;
  logic [1:0] aptr_q;
  logic [7:0] trim_q;
  logic [rtccv_pkg::PRESC_W-1:0] presc_q;
  logic signed [rtccv_pkg::ADJ_W-1:0] adj_q;
  logic xtal_s1_q;
  logic xtal_s2_q;
  logic xtal_s3_q;
  logic xtal_edge;
  logic xtal_run;
  logic [rtccv_pkg::PRESC_W:0] presc_sum;
  logic [rtccv_pkg::PRESC_W:0] step;
  logic sec_tick;
  logic minute_tick;
  logic wr_cfg;
  logic wr_tval;
  logic wr_acfg;
  logic wr_aval;
  logic acc_tval;
  logic acc_aval;
  logic [15:0] tval_rd;
  logic [15:0] aval_rd;
  logic [15:0] rd_d;
  logic [15:0] cfg_rd;

  // bcd increment with wrap from max back to min
  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] max, input logic [7:0] min);
    logic [7:0] r;
    r = v;
    if (v == max) begin
      r = min;
    end else if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction : bcd_inc

  // last day of month; leap when bcd year divisible by four
  function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    logic [7:0] r;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      8'h02: r = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
      default: r = 8'h31;
    endcase
    return r;
  endfunction : month_end

  // pointer walks down one pair per access and parks at zero
  function automatic logic [1:0] ptr_next(input logic [1:0] p);
    logic [1:0] r;
    r = p;
    if (p != rtccv_pkg::PTR_MINUTE_SECOND_VALUE) begin
      r = p - 2'h1;
    end
    return r;
  endfunction : ptr_next

  // crystal pin crosses into i_clk; only stage 2 onward is looked at
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xtal_s1_q <= 1'b0;
      xtal_s2_q <= 1'b0;
      xtal_s3_q <= 1'b0;
    end else begin
      xtal_s1_q <= i_xtal;
      xtal_s2_q <= xtal_s1_q;
      xtal_s3_q <= xtal_s2_q;
    end
  end
  assign xtal_edge = xtal_s2_q & ~xtal_s3_q;
  assign xtal_run = en_q && xtal_edge;

  assign wr_cfg = i_wr && (i_addr == rtccv_pkg::REG_CFG);
  assign wr_tval = i_wr && (i_addr == rtccv_pkg::REG_TVAL);
  assign wr_acfg = i_wr && (i_addr == rtccv_pkg::REG_ACFG);
  assign wr_aval = i_wr && (i_addr == rtccv_pkg::REG_AVAL);
  // the bus has no byte lanes, so every window access touches the high byte
  assign acc_tval = (i_wr || i_rd) && (i_addr == rtccv_pkg::REG_TVAL);
  assign acc_aval = (i_wr || i_rd) && (i_addr == rtccv_pkg::REG_AVAL);

  // pending adjust is spread over crystal pulses: double steps or skipped steps
  always_comb begin
    if (adj_q > 0) begin
      step = 16'h0002;
    end else if (adj_q < 0) begin
      step = 16'h0000;
    end else begin
      step = 16'h0001;
    end
  end
  assign presc_sum = {1'b0, presc_q} + step;
  assign sec_tick = xtal_run && presc_sum[rtccv_pkg::PRESC_W];
  assign minute_tick = sec_tick && (time_q.second == rtccv_pkg::MAX_SEC);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      presc_q <= '0;
      adj_q <= '0;
    end else begin
      if (wr_tval && unlock_q && ptr_q == rtccv_pkg::PTR_MINUTE_SECOND_VALUE) begin
        presc_q <= '0;
      end else if (xtal_run) begin
        presc_q <= presc_sum[rtccv_pkg::PRESC_W-1:0];
      end
      // trim times four spans -512 to 508, so ten signed bits hold it exactly
      if (minute_tick) begin
        adj_q <= {trim_q, 2'b00};
      end else if (xtal_run && adj_q > 0) begin
        adj_q <= adj_q - 10'sd1;
      end else if (xtal_run && adj_q < 0) begin
        adj_q <= adj_q + 10'sd1;
      end
    end
  end

  always_comb begin
    time_adv = time_q;
    time_adv.second = bcd_inc(time_q.second, rtccv_pkg::MAX_SEC, rtccv_pkg::BCD_ZERO);
    if (time_q.second == rtccv_pkg::MAX_SEC) begin
      time_adv.minute = bcd_inc(time_q.minute, rtccv_pkg::MAX_MIN, rtccv_pkg::BCD_ZERO);
      if (time_q.minute == rtccv_pkg::MAX_MIN) begin
        time_adv.hour = bcd_inc(time_q.hour, rtccv_pkg::MAX_HOUR, rtccv_pkg::BCD_ZERO);
        if (time_q.hour == rtccv_pkg::MAX_HOUR) begin
          time_adv.weekday_digit = bcd_inc(time_q.weekday_digit, rtccv_pkg::MAX_WEEKDAY_DIGIT, rtccv_pkg::BCD_ZERO);
          time_adv.mday = bcd_inc(time_q.mday, month_end(time_q.month, time_q.year), rtccv_pkg::BCD_ONE);
          if (time_q.mday == month_end(time_q.month, time_q.year)) begin
            time_adv.month = bcd_inc(time_q.month, rtccv_pkg::MAX_MONTH, rtccv_pkg::BCD_ONE);
            if (time_q.month == rtccv_pkg::MAX_MONTH) begin
              time_adv.year = bcd_inc(time_q.year, rtccv_pkg::MAX_YEAR, rtccv_pkg::BCD_ZERO);
            end
          end
        end
      end
    end
  end

  // a software write wins over the tick for the pair it writes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      time_q <= '0;
      time_q.mday <= rtccv_pkg::RST_MDAY;
      time_q.month <= rtccv_pkg::RST_MONTH;
    end else begin
      if (sec_tick) begin
        time_q <= time_adv;
      end
      if (wr_tval && unlock_q) begin
        case (ptr_q)
          rtccv_pkg::PTR_MINUTE_SECOND_VALUE: begin
            time_q.minute <= i_wdata[15:8] & rtccv_pkg::MASK_MIN;
            time_q.second <= i_wdata[7:0] & rtccv_pkg::MASK_SEC;
          end
          rtccv_pkg::PTR_WDHR: begin
            time_q.weekday_digit <= i_wdata[15:8] & rtccv_pkg::MASK_WEEKDAY_DIGIT;
            time_q.hour <= i_wdata[7:0] & rtccv_pkg::MASK_HOUR;
          end
          rtccv_pkg::PTR_MONTH_DAY_VALUE: begin
            // month bits stay read-only here
            time_q.mday <= i_wdata[7:0] & rtccv_pkg::MASK_MDAY;
          end
          default: begin
            time_q.year <= i_wdata[7:0] & rtccv_pkg::MASK_YEAR;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alarm_q <= '0;
    end else if (wr_aval) begin
      case (aptr_q)
        rtccv_pkg::PTR_MINUTE_SECOND_VALUE: begin
          alarm_q.minute <= i_wdata[15:8] & rtccv_pkg::MASK_MIN;
          alarm_q.second <= i_wdata[7:0] & rtccv_pkg::MASK_SEC;
        end
        rtccv_pkg::PTR_WDHR: begin
          if (unlock_q) begin
            alarm_q.weekday_digit <= i_wdata[15:8] & rtccv_pkg::MASK_WEEKDAY_DIGIT;
            alarm_q.hour <= i_wdata[7:0] & rtccv_pkg::MASK_HOUR;
          end
        end
        rtccv_pkg::PTR_MONTH_DAY_VALUE: begin
          if (unlock_q) begin
            alarm_q.month <= i_wdata[15:8] & rtccv_pkg::MASK_MONTH;
            alarm_q.mday <= i_wdata[7:0] & rtccv_pkg::MASK_MDAY;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_q <= 1'b0;
      unlock_q <= 1'b0;
      ptr_q <= rtccv_pkg::PTR_MINUTE_SECOND_VALUE;
      aptr_q <= rtccv_pkg::PTR_MINUTE_SECOND_VALUE;
      trim_q <= 8'h00;
    end else begin
      if (wr_cfg) begin
        unlock_q <= i_wdata[rtccv_pkg::CFG_UNLOCK_BIT];
        ptr_q <= i_wdata[rtccv_pkg::CFG_PTR_LSB +: 2];
        trim_q <= i_wdata[rtccv_pkg::CFG_TRIM_LSB +: 8];
        if (unlock_q) begin
          en_q <= i_wdata[rtccv_pkg::CFG_EN_BIT];
        end
      end else if (acc_tval) begin
        ptr_q <= ptr_next(ptr_q);
      end
      if (wr_acfg) begin
        aptr_q <= i_wdata[rtccv_pkg::CFG_PTR_LSB +: 2];
      end else if (acc_aval) begin
        aptr_q <= ptr_next(aptr_q);
      end
    end
  end

  always_comb begin
    cfg_rd = {en_q, 1'b0, unlock_q, 1'b0, presc_q[rtccv_pkg::HALF_BIT], 1'b0, ptr_q, trim_q};
    case (ptr_q)
      rtccv_pkg::PTR_MINUTE_SECOND_VALUE: tval_rd = {time_q.minute, time_q.second};
      rtccv_pkg::PTR_WDHR: tval_rd = {time_q.weekday_digit, time_q.hour};
      rtccv_pkg::PTR_MONTH_DAY_VALUE: tval_rd = {time_q.month, time_q.mday};
      default: tval_rd = {8'h00, time_q.year};
    endcase
    case (aptr_q)
      rtccv_pkg::PTR_MINUTE_SECOND_VALUE: aval_rd = {alarm_q.minute, alarm_q.second};
      rtccv_pkg::PTR_WDHR: aval_rd = {alarm_q.weekday_digit, alarm_q.hour};
      rtccv_pkg::PTR_MONTH_DAY_VALUE: aval_rd = {alarm_q.month, alarm_q.mday};
      default: aval_rd = 16'h0000;
    endcase
    case (i_addr)
      rtccv_pkg::REG_CFG: rd_d = cfg_rd;
      rtccv_pkg::REG_TVAL: rd_d = tval_rd;
      rtccv_pkg::REG_ACFG: rd_d = {6'h00, aptr_q, 8'h00};
      default: rd_d = aval_rd;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= i_rd ? rd_d : 16'h0000;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_second_pulse <= 1'b0;
    end else begin
      o_second_pulse <= sec_tick;
    end
  end
endmodule : rtccv_core
`default_nettype wire

// ---- rtl/rtccv_pkg.sv ----
`default_nettype none
package rtccv_pkg;
  localparam int ADDR_W = 2;
  localparam int DATA_W = 16;
  // register indexes on the plain port
  localparam logic [1:0] REG_CFG = 2'h0;
  localparam logic [1:0] REG_TVAL = 2'h1;
  localparam logic [1:0] REG_ACFG = 2'h2;
  localparam logic [1:0] REG_AVAL = 2'h3;
  // configuration field positions
  localparam int CFG_EN_BIT = 15;
  localparam int CFG_UNLOCK_BIT = 13;
  localparam int CFG_HALF_BIT = 11;
  localparam int CFG_PTR_LSB = 8;
  localparam int CFG_TRIM_LSB = 0;
  // window pointer codes
  localparam logic [1:0] PTR_MINUTE_SECOND_VALUE = 2'h0;
  localparam logic [1:0] PTR_WDHR = 2'h1;
  localparam logic [1:0] PTR_MONTH_DAY_VALUE = 2'h2;
  localparam logic [1:0] PTR_YEAR = 2'h3;
  // implemented bits of each byte field
  localparam logic [7:0] MASK_YEAR = 8'hff;
  localparam logic [7:0] MASK_MONTH = 8'h1f;
  localparam logic [7:0] MASK_MDAY = 8'h3f;
  localparam logic [7:0] MASK_WEEKDAY_DIGIT = 8'h07;
  localparam logic [7:0] MASK_HOUR = 8'h3f;
  localparam logic [7:0] MASK_MIN = 8'h7f;
  localparam logic [7:0] MASK_SEC = 8'h7f;
  // rollover limits in bcd
  localparam logic [7:0] MAX_SEC = 8'h59;
  localparam logic [7:0] MAX_MIN = 8'h59;
  localparam logic [7:0] MAX_HOUR = 8'h23;
  localparam logic [7:0] MAX_WEEKDAY_DIGIT = 8'h06;
  localparam logic [7:0] MAX_MONTH = 8'h12;
  localparam logic [7:0] MAX_YEAR = 8'h99;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  // reset values (field contents are undefined on the real part)
  localparam logic [7:0] RST_MDAY = 8'h01;
  localparam logic [7:0] RST_MONTH = 8'h01;
  // prescaler: crystal pulses per second
  localparam int PRESC_W = 15;
  localparam int HALF_BIT = 14;
  localparam int ADJ_W = 10;
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] mday;
    logic [7:0] weekday_digit;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } rtccv_time_type;
endpackage : rtccv_pkg
`default_nettype wire

// ---- testbench/rtccv_core_assertions.sv ----
`default_nettype none
module rtccv_core_assertions (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_xtal,
  input wire logic [rtccv_pkg::ADDR_W-1:0] i_addr,
  input wire logic [rtccv_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [rtccv_pkg::DATA_W-1:0] o_rdata,
  input wire logic o_second_pulse
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence wr_at(logic [1:0] a);
    i_wr && i_addr == a;
  endsequence
  sequence wr_ptr(logic [1:0] a, logic [1:0] p);
    i_wr && i_addr == a && i_wdata[9:8] == p;
  endsequence
  sequence rd_at(logic [1:0] a);
    i_rd && i_addr == a;
  endsequence
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000) else $error("stale read data");
  tval_top_a: assert property (rd_at(rtccv_pkg::REG_TVAL) |=> !o_rdata[15]) else $error("value bit 15 set");
  cfg_zero_a: assert property (rd_at(rtccv_pkg::REG_CFG) |=> o_rdata[14] == 1'b0 && o_rdata[12] == 1'b0
    && o_rdata[10] == 1'b0) else $error("config spare bits set");
  cfg_echo_a: assert property (wr_at(rtccv_pkg::REG_CFG) ##1 rd_at(rtccv_pkg::REG_CFG) |=>
    o_rdata[13] == $past(i_wdata[13], 2) && o_rdata[9:0] == $past(i_wdata[9:0], 2)) else $error("config echo");
  ptr_dec_a: assert property (wr_at(rtccv_pkg::REG_CFG) ##1 rd_at(rtccv_pkg::REG_TVAL) ##1 rd_at(rtccv_pkg::REG_CFG)
    |=> o_rdata[9:8] == (($past(i_wdata[9:8], 3) == 2'h0) ? 2'h0 : $past(i_wdata[9:8], 3) - 2'h1))
    else $error("pointer step");
  half_clear_a: assert property ((wr_ptr(rtccv_pkg::REG_CFG, 2'h0) and i_wdata[13]) ##1 wr_at(rtccv_pkg::REG_TVAL)
    ##1 rd_at(rtccv_pkg::REG_CFG) |=> !o_rdata[11] && o_rdata[9:8] == 2'h0) else $error("half flag kept");
  alarm_ms_a: assert property (wr_ptr(rtccv_pkg::REG_ACFG, 2'h0) ##1 wr_at(rtccv_pkg::REG_AVAL)
    ##1 wr_ptr(rtccv_pkg::REG_ACFG, 2'h0) ##1 rd_at(rtccv_pkg::REG_AVAL)
    |=> o_rdata == ($past(i_wdata, 3) & 16'h7f7f)) else $error("alarm min/sec");
  alarm_ptr3_a: assert property (wr_ptr(rtccv_pkg::REG_ACFG, 2'h3) ##1 rd_at(rtccv_pkg::REG_AVAL)
    |=> o_rdata == 16'h0000) else $error("alarm slot 3 not zero");
  pulse_single_a: assert property (o_second_pulse |=> !o_second_pulse) else $error("second pulse long");
endmodule : rtccv_core_assertions
bind rtccv_core rtccv_core_assertions chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_xtal(i_xtal), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_second_pulse(o_second_pulse));
`default_nettype wire

// ---- testbench/rtc_calendar_value_and_calibration_tb.sv ----
`default_nettype none
module rtc_calendar_value_and_calibration_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk, i_rst_n, i_xtal, i_wr, i_rd, o_second_pulse, chk_pend, ul;
  logic [1:0] i_addr;
  logic [15:0] i_wdata, o_rdata, exp_next, chk_exp, v;
  logic [7:0] trim;
  logic [15:0] tv [4];
  logic [15:0] av [3];
  int n_fail, n_compared;
  rtccv_core dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_xtal(i_xtal), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_second_pulse(o_second_pulse));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // slow enough for the two-flop synchroniser
  initial begin
    i_xtal = 1'b0;
    forever begin
      repeat (4) @(posedge i_clk);
      i_xtal <= ~i_xtal;
    end
  end
  task automatic give_verdict();
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp16
  task automatic cmp1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp1
  // strobes stay up between calls so accesses run back to back
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    i_addr <= a;
    i_wdata <= d;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_wr <= 1'b0;
    i_addr <= a;
    exp_next <= e;
  endtask : rd
  always @(posedge i_clk) begin
    if (chk_pend === 1'b1) cmp16(o_rdata, chk_exp);
    chk_pend <= i_rd;
    chk_exp <= exp_next;
  end
  function automatic logic [15:0] cfg_w(input logic u, input logic [1:0] p, input logic [7:0] t);
    return {2'b00, u, 3'b000, p, t};
  endfunction : cfg_w
  // time month is never written, so it keeps its reset value
  function automatic logic [15:0] tmask(input logic [1:0] p, input logic [15:0] d);
    case (p)
      2'h3: return d & 16'h00ff;
      2'h2: return 16'h0100 | (d & 16'h003f);
      2'h1: return d & 16'h073f;
      default: return d & 16'h7f7f;
    endcase
  endfunction : tmask
  function automatic logic [15:0] amask(input logic [1:0] p, input logic [15:0] d);
    return d & ((p == 2'h2) ? 16'h1f3f : (p == 2'h1) ? 16'h073f : 16'h7f7f);
  endfunction : amask
  task automatic tw(input logic [1:0] p);
    v = 16'($urandom);
    wr(rtccv_pkg::REG_TVAL, v);
    if (ul) tv[p] = tmask(p, v);
  endtask : tw
  initial begin
    repeat (3000) @(posedge i_clk);
    n_fail++;
    give_verdict();
  end
  initial begin
    {i_rst_n, i_wr, i_rd, i_addr, i_wdata, exp_next} = '0;
    n_fail = 0;
    n_compared = 0;
    v = 16'($urandom(32'h28bef07b));
    tv = '{16'h0000, 16'h0000, 16'h0101, 16'h0000};
    av = '{default: 16'h0000};
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(rtccv_pkg::REG_CFG, 16'h0000);
    wr(rtccv_pkg::REG_CFG, 16'h8300);
    for (int p = 3; p >= 0; p--) rd(rtccv_pkg::REG_TVAL, tv[p]);
    rd(rtccv_pkg::REG_TVAL, tv[0]);
    for (int k = 0; k < 6; k++) begin
      ul = k[0];
      trim = 8'($urandom);
      if (k == 2) trim = 8'h80;
      if (k == 4) trim = 8'(((32768 - 32770) * 60) / 4);
      wr(rtccv_pkg::REG_CFG, cfg_w(ul, 2'h3, trim));
      rd(rtccv_pkg::REG_CFG, cfg_w(ul, 2'h3, trim));
      for (int p = 3; p > 0; p--) tw(p[1:0]);
      wr(rtccv_pkg::REG_CFG, cfg_w(ul, 2'h0, trim));
      tw(2'h0);
      rd(rtccv_pkg::REG_CFG, cfg_w(ul, 2'h0, trim));
      wr(rtccv_pkg::REG_CFG, cfg_w(ul, 2'h3, trim));
      rd(rtccv_pkg::REG_TVAL, tv[3]);
      rd(rtccv_pkg::REG_CFG, cfg_w(ul, 2'h2, trim));
      for (int p = 2; p >= 0; p--) rd(rtccv_pkg::REG_TVAL, tv[p]);
      wr(rtccv_pkg::REG_ACFG, 16'h0300);
      rd(rtccv_pkg::REG_AVAL, 16'h0000);
      wr(rtccv_pkg::REG_ACFG, 16'h0200);
      for (int p = 2; p >= 0; p--) begin
        v = 16'($urandom);
        wr(rtccv_pkg::REG_AVAL, v);
        if (ul || p == 0) av[p] = amask(p[1:0], v);
      end
      wr(rtccv_pkg::REG_ACFG, 16'h0200);
      for (int p = 2; p >= 0; p--) rd(rtccv_pkg::REG_AVAL, av[p]);
    end
    v = 16'($urandom);
    wr(rtccv_pkg::REG_ACFG, 16'h0000);
    wr(rtccv_pkg::REG_AVAL, v);
    wr(rtccv_pkg::REG_ACFG, 16'h0000);
    rd(rtccv_pkg::REG_AVAL, v & 16'h7f7f);
    wr(rtccv_pkg::REG_CFG, 16'h0000);
    wr(rtccv_pkg::REG_CFG, 16'h8000);
    rd(rtccv_pkg::REG_CFG, 16'h0000);
    wr(rtccv_pkg::REG_CFG, 16'h2000);
    wr(rtccv_pkg::REG_CFG, 16'ha000);
    rd(rtccv_pkg::REG_CFG, 16'ha000);
    wr(rtccv_pkg::REG_CFG, 16'ha000);
    @(posedge i_clk);
    i_wr <= 1'b0;
    repeat (3) @(posedge i_clk);
    // timer only just enabled, so no whole second can have passed
    cmp1(o_second_pulse, 1'b0);
    give_verdict();
  end
endmodule : rtc_calendar_value_and_calibration_tb
`default_nettype wire
